// ### design/crr_core_register_reset_init.sv
// Reset and wake-up initialisation of the core special-function registers
// Summary of operation
// - Master-clear, watchdog, reset-instruction and stack resets share one value set
// - Stack top registers clear on any reset, kept on wake unless enabled interrupt
// - Power-on clears stack pointer bits, keeps flags; other resets clear all
// - Program-counter latches and low byte clear on resets; latches kept on wake
// - On wake the program-counter low byte takes the low byte of the resume address: the vector or program counter plus two
// - Table pointer and table latch clear on resets and hold across wake
// - Product, working and indirect pointer 0 undefined at power-on, else kept
// - Primary interrupt control clears bits 7..1; bit 0 undefined or kept
// - Second interrupt control register becomes all ones on every reset
// - Third interrupt control register becomes 1100_0000 on every reset
// - Interrupt wake sets the flag bits of its source
// - Enabled interrupt wake copies the program counter into the stack top
// - Enabled interrupt wake advances the stack pointer, or sets the full flag when it is at its top
// - Enabled interrupt wake loads vector 0008h or 0018h
// - Unimplemented bits read as zero
// - Port A bits 6 and 7 work only when the oscillator frees them
// - Indirect virtual locations hold no storage and no reset value
// - Watchdog wake, or interrupt wake with both enable bits clear, resumes at program counter plus two
//
// Added by the designer: the Avalon-MM register port and the register addresses.
module crr_core_register_reset_init #(
  parameter int ADDR_W = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [ADDR_W-1:0]        avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     por_event,
  input  wire logic                     reset_event,
  input  wire logic                     wake_wdt,
  input  wire logic                     wake_irq,
  input  wire logic                     wake_irq_high,
  input  wire logic [7:0]               wake_flag_set,
  input  wire logic [crr_pkg::PC_W-1:0] current_pc,
  input  wire logic                     osc_frees_pins,
  input  wire logic                     master_clear_input_n,
  input  wire logic [7:0]               port_a_pins,
  output logic      [7:0]               port_a_out,
  output logic      [7:0]               port_a_out_en_n,
  output logic      [crr_pkg::PC_W-1:0] resume_pc,
  output logic                          resume_valid,
  output logic                          irq
);

  // ==========================================================================
  // Storage
  logic [4:0]  stack_top_upper;
  logic [7:0]  stack_top_high;
  logic [7:0]  stack_top_low;
  logic [4:0]  stack_ptr;
  logic        stack_full;
  logic        stack_under;
  logic [4:0]  pc_latch_upper;
  logic [7:0]  pc_latch_high;
  logic [7:0]  pc_low_byte;
  logic [5:0]  table_pointer_upper;
  logic [7:0]  table_pointer_high;
  logic [7:0]  table_pointer_low;
  logic [7:0]  table_data_latch;
  logic [7:0]  multiply_result_high;
  logic [7:0]  multiply_result_low;
  logic [3:0]  indirect_ptr0_high;
  logic [7:0]  indirect_ptr0_low;
  logic [7:0]  working_accumulator;
  logic [6:0]  irq_primary_upper;
  logic        irq_primary_bit0;
  logic [7:0]  irq_control_second;
  logic [7:0]  irq_control_third;
  logic [7:0]  port_a_latch;
  logic [7:0]  port_a_direction;
  logic [7:0]  pins_meta;
  logic [7:0]  pins_sync;
  logic        master_clear_input_meta;
  logic        master_clear_input_sync_n;
  logic [crr_pkg::EV_W-1:0] event_status;
  logic [crr_pkg::EV_W-1:0] event_mask;

  // ==========================================================================
  // Event decode; power-on outranks other resets, which outrank wake-ups
  logic                     do_por;
  logic                     do_rst;
  logic                     do_wake;
  logic                     irq_vec;
  logic [7:0]               irq_control_primary;
  logic [7:0]               pa_enable;
  logic [crr_pkg::PC_W-1:0] next_pc;

  assign irq_control_primary = {irq_primary_upper, irq_primary_bit0};
  assign do_por  = por_event;
  assign do_rst  = !por_event && (reset_event || !master_clear_input_sync_n);
  assign do_wake = !do_por && !do_rst && (wake_wdt || wake_irq);
  assign irq_vec = do_wake && wake_irq &&
                   (irq_control_primary[crr_pkg::GIE_HIGH_BIT] ||
                    irq_control_primary[crr_pkg::GIE_LOW_BIT]);
  // Oscillator-owned pins stay dead so a crystal is never loaded by a driver
  assign pa_enable = osc_frees_pins ? 8'hFF : ~crr_pkg::PORT_A_OSC_BITS;

  always_comb begin
    if (irq_vec) begin
      next_pc = wake_irq_high ? crr_pkg::VECTOR_HIGH : crr_pkg::VECTOR_LOW;
    end else begin
      next_pc = current_pc + crr_pkg::PC_STEP;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta   <= 8'h00;
      pins_sync   <= 8'h00;
      master_clear_input_meta   <= 1'b1;
      master_clear_input_sync_n <= 1'b1;
    end else begin
      pins_meta   <= port_a_pins;
      pins_sync   <= pins_meta;
      master_clear_input_meta   <= master_clear_input_n;
      master_clear_input_sync_n <= master_clear_input_meta;
    end
  end

  // ==========================================================================
  // Bus slave: answers every request one cycle after it is seen
  logic        wr_en;
  logic [7:0]  wd;
  logic [31:0] next_rdata;

  assign wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wd    = avs_writedata[7:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_rdata;
    end
  end

  // Narrow registers zero-extend, so unimplemented bits read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (avs_address == crr_pkg::OFS_STACK_TOP_UPPER) begin
      next_rdata[4:0] = stack_top_upper;
    end else if (avs_address == crr_pkg::OFS_STACK_TOP_HIGH) begin
      next_rdata[7:0] = stack_top_high;
    end else if (avs_address == crr_pkg::OFS_STACK_TOP_LOW) begin
      next_rdata[7:0] = stack_top_low;
    end else if (avs_address == crr_pkg::OFS_RETURN_STACK_PTR) begin
      next_rdata[7:0] = {stack_full, stack_under, 1'b0, stack_ptr};
    end else if (avs_address == crr_pkg::OFS_PC_LATCH_UPPER) begin
      next_rdata[4:0] = pc_latch_upper;
    end else if (avs_address == crr_pkg::OFS_PC_LATCH_HIGH) begin
      next_rdata[7:0] = pc_latch_high;
    end else if (avs_address == crr_pkg::OFS_PC_LOW_BYTE) begin
      next_rdata[7:0] = pc_low_byte;
    end else if (avs_address == crr_pkg::OFS_TABLE_PTR_UPPER) begin
      next_rdata[5:0] = table_pointer_upper;
    end else if (avs_address == crr_pkg::OFS_TABLE_PTR_HIGH) begin
      next_rdata[7:0] = table_pointer_high;
    end else if (avs_address == crr_pkg::OFS_TABLE_PTR_LOW) begin
      next_rdata[7:0] = table_pointer_low;
    end else if (avs_address == crr_pkg::OFS_TABLE_DATA_LATCH) begin
      next_rdata[7:0] = table_data_latch;
    end else if (avs_address == crr_pkg::OFS_MULT_RESULT_HIGH) begin
      next_rdata[7:0] = multiply_result_high;
    end else if (avs_address == crr_pkg::OFS_MULT_RESULT_LOW) begin
      next_rdata[7:0] = multiply_result_low;
    end else if (avs_address == crr_pkg::OFS_IRQ_CTRL_PRIMARY) begin
      next_rdata[7:0] = irq_control_primary;
    end else if (avs_address == crr_pkg::OFS_IRQ_CTRL_SECOND) begin
      next_rdata[7:0] = irq_control_second;
    end else if (avs_address == crr_pkg::OFS_IRQ_CTRL_THIRD) begin
      next_rdata[7:0] = irq_control_third;
    end else if (avs_address == crr_pkg::OFS_INDIRECT_PTR0_HI) begin
      next_rdata[3:0] = indirect_ptr0_high;
    end else if (avs_address == crr_pkg::OFS_INDIRECT_PTR0_LO) begin
      next_rdata[7:0] = indirect_ptr0_low;
    end else if (avs_address == crr_pkg::OFS_WORKING_ACC) begin
      next_rdata[7:0] = working_accumulator;
    end else if (avs_address == crr_pkg::OFS_PORT_A_DATA) begin
      next_rdata[7:0] = pins_sync & pa_enable;
    end else if (avs_address == crr_pkg::OFS_PORT_A_LATCH) begin
      next_rdata[7:0] = port_a_latch & pa_enable;
    end else if (avs_address == crr_pkg::OFS_PORT_A_DIRECTION) begin
      next_rdata[7:0] = port_a_direction & pa_enable;
    end else if (avs_address == crr_pkg::OFS_EVENT_STATUS) begin
      next_rdata[crr_pkg::EV_W-1:0] = event_status;
    end else if (avs_address == crr_pkg::OFS_EVENT_MASK) begin
      next_rdata[crr_pkg::EV_W-1:0] = event_mask;
    end else if (avs_address >= crr_pkg::OFS_INDIRECT_FIRST &&
                 avs_address <= crr_pkg::OFS_INDIRECT_LAST) begin
      // Virtual locations have no storage behind them here
      next_rdata = 32'h0000_0000;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Stack top and stack pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_upper <= crr_pkg::RST_STACK_TOP_UPPER;
      stack_top_high  <= crr_pkg::RST_BYTE_ZERO;
      stack_top_low   <= crr_pkg::RST_BYTE_ZERO;
    end else if (do_por || do_rst) begin
      stack_top_upper <= crr_pkg::RST_STACK_TOP_UPPER;
      stack_top_high  <= crr_pkg::RST_BYTE_ZERO;
      stack_top_low   <= crr_pkg::RST_BYTE_ZERO;
    end else if (irq_vec) begin
      stack_top_upper <= current_pc[20:16];
      stack_top_high  <= current_pc[15:8];
      stack_top_low   <= current_pc[7:0];
    end else if (wr_en && avs_address == crr_pkg::OFS_STACK_TOP_UPPER) begin
      stack_top_upper <= wd[4:0];
    end else if (wr_en && avs_address == crr_pkg::OFS_STACK_TOP_HIGH) begin
      stack_top_high <= wd;
    end else if (wr_en && avs_address == crr_pkg::OFS_STACK_TOP_LOW) begin
      stack_top_low <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr   <= crr_pkg::RST_STACK_PTR;
      stack_full  <= 1'b0;
      stack_under <= 1'b0;
    end else if (do_por) begin
      stack_ptr <= crr_pkg::RST_STACK_PTR;
    end else if (do_rst) begin
      stack_ptr   <= crr_pkg::RST_STACK_PTR;
      stack_full  <= 1'b0;
      stack_under <= 1'b0;
    end else if (irq_vec) begin
      // A push on the last slot flags overflow instead of wrapping
      if (stack_ptr == crr_pkg::STK_PTR_MAX) begin
        stack_full <= 1'b1;
      end else begin
        stack_ptr <= stack_ptr + 5'h01;
      end
    end else if (wr_en && avs_address == crr_pkg::OFS_RETURN_STACK_PTR) begin
      stack_ptr   <= wd[4:0];
      stack_full  <= wd[crr_pkg::STK_FULL_BIT];
      stack_under <= wd[crr_pkg::STK_UNDER_BIT];
    end
  end

  // ==========================================================================
  // Program counter latches and low byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_latch_upper <= crr_pkg::RST_STACK_TOP_UPPER;
      pc_latch_high  <= crr_pkg::RST_BYTE_ZERO;
      pc_low_byte    <= crr_pkg::RST_BYTE_ZERO;
    end else if (do_por || do_rst) begin
      pc_latch_upper <= crr_pkg::RST_STACK_TOP_UPPER;
      pc_latch_high  <= crr_pkg::RST_BYTE_ZERO;
      pc_low_byte    <= crr_pkg::RST_BYTE_ZERO;
    end else if (do_wake) begin
      pc_low_byte <= next_pc[7:0];
    end else if (wr_en && avs_address == crr_pkg::OFS_PC_LATCH_UPPER) begin
      pc_latch_upper <= wd[4:0];
    end else if (wr_en && avs_address == crr_pkg::OFS_PC_LATCH_HIGH) begin
      pc_latch_high <= wd;
    end else if (wr_en && avs_address == crr_pkg::OFS_PC_LOW_BYTE) begin
      pc_low_byte <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_pc    <= '0;
      resume_valid <= 1'b0;
    end else if (do_por || do_rst) begin
      resume_pc    <= '0;
      resume_valid <= 1'b1;
    end else if (do_wake) begin
      resume_pc    <= next_pc;
      resume_valid <= 1'b1;
    end else begin
      resume_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Table pointer and latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer_upper <= crr_pkg::RST_TABLE_PTR_UPPER;
      table_pointer_high  <= crr_pkg::RST_BYTE_ZERO;
      table_pointer_low   <= crr_pkg::RST_BYTE_ZERO;
      table_data_latch    <= crr_pkg::RST_BYTE_ZERO;
    end else if (do_por || do_rst) begin
      table_pointer_upper <= crr_pkg::RST_TABLE_PTR_UPPER;
      table_pointer_high  <= crr_pkg::RST_BYTE_ZERO;
      table_pointer_low   <= crr_pkg::RST_BYTE_ZERO;
      table_data_latch    <= crr_pkg::RST_BYTE_ZERO;
    end else if (wr_en && avs_address == crr_pkg::OFS_TABLE_PTR_UPPER) begin
      table_pointer_upper <= wd[5:0];
    end else if (wr_en && avs_address == crr_pkg::OFS_TABLE_PTR_HIGH) begin
      table_pointer_high <= wd;
    end else if (wr_en && avs_address == crr_pkg::OFS_TABLE_PTR_LOW) begin
      table_pointer_low <= wd;
    end else if (wr_en && avs_address == crr_pkg::OFS_TABLE_DATA_LATCH) begin
      table_data_latch <= wd;
    end
  end

  // ==========================================================================
  // Data registers: deliberately without reset, so power-on leaves them
  // unknown and every reset or wake-up leaves them untouched
  always_ff @(posedge clk) begin
    if (wr_en && avs_address == crr_pkg::OFS_MULT_RESULT_HIGH) begin
      multiply_result_high <= wd;
    end
    if (wr_en && avs_address == crr_pkg::OFS_MULT_RESULT_LOW) begin
      multiply_result_low <= wd;
    end
    if (wr_en && avs_address == crr_pkg::OFS_INDIRECT_PTR0_HI) begin
      indirect_ptr0_high <= wd[3:0];
    end
    if (wr_en && avs_address == crr_pkg::OFS_INDIRECT_PTR0_LO) begin
      indirect_ptr0_low <= wd;
    end
    if (wr_en && avs_address == crr_pkg::OFS_WORKING_ACC) begin
      working_accumulator <= wd;
    end
  end

  // ==========================================================================
  // Interrupt control registers
  always_ff @(posedge clk) begin
    if (do_wake && wake_irq) begin
      irq_primary_bit0 <= irq_primary_bit0 | wake_flag_set[0];
    end else if (wr_en && avs_address == crr_pkg::OFS_IRQ_CTRL_PRIMARY) begin
      irq_primary_bit0 <= wd[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_primary_upper  <= crr_pkg::RST_IRQ_PRIMARY_HI;
      irq_control_second <= crr_pkg::RST_IRQ_SECOND;
      irq_control_third  <= crr_pkg::RST_IRQ_THIRD;
    end else if (do_por || do_rst) begin
      irq_primary_upper  <= crr_pkg::RST_IRQ_PRIMARY_HI;
      irq_control_second <= crr_pkg::RST_IRQ_SECOND;
      irq_control_third  <= crr_pkg::RST_IRQ_THIRD;
    end else if (do_wake && wake_irq) begin
      irq_primary_upper <= irq_primary_upper | wake_flag_set[7:1];
    end else if (wr_en && avs_address == crr_pkg::OFS_IRQ_CTRL_PRIMARY) begin
      irq_primary_upper <= wd[7:1];
    end else if (wr_en && avs_address == crr_pkg::OFS_IRQ_CTRL_SECOND) begin
      irq_control_second <= wd;
    end else if (wr_en && avs_address == crr_pkg::OFS_IRQ_CTRL_THIRD) begin
      irq_control_third <= wd;
    end
  end

  // ==========================================================================
  // Port A
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_latch     <= crr_pkg::RST_BYTE_ZERO;
      port_a_direction <= crr_pkg::RST_PORT_A_DIR;
    end else if (wr_en && avs_address == crr_pkg::OFS_PORT_A_LATCH) begin
      port_a_latch <= wd;
    end else if (wr_en && avs_address == crr_pkg::OFS_PORT_A_DIRECTION) begin
      port_a_direction <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_out      <= 8'h00;
      port_a_out_en_n <= 8'hFF;
    end else begin
      port_a_out      <= port_a_latch & pa_enable;
      port_a_out_en_n <= port_a_direction | ~pa_enable;
    end
  end

  // ==========================================================================
  // Event status, mask and interrupt line; a new event beats a clear
  logic [crr_pkg::EV_W-1:0] ev_set;
  logic [crr_pkg::EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[crr_pkg::EV_POWER_ON] = do_por;
    ev_set[crr_pkg::EV_RESET]    = do_rst;
    ev_set[crr_pkg::EV_WAKE_WDT] = do_wake && wake_wdt;
    ev_set[crr_pkg::EV_WAKE_IRQ] = do_wake && wake_irq;
    ev_clr = '0;
    if (wr_en && avs_address == crr_pkg::OFS_EVENT_STATUS) begin
      ev_clr = wd[crr_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_status <= '0;
    end else begin
      event_status <= (event_status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_mask <= '0;
    end else if (wr_en && avs_address == crr_pkg::OFS_EVENT_MASK) begin
      event_mask <= wd[crr_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

endmodule // crr_core_register_reset_init

// ### design/crr_pkg.sv
// Constants for the core register reset and wake-up initialisation block
package crr_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W = 21;

  // ==========================================================================
  // Register byte addresses (one aligned word each)
  localparam logic [7:0] OFS_STACK_TOP_UPPER   = 8'h00;
  localparam logic [7:0] OFS_STACK_TOP_HIGH    = 8'h04;
  localparam logic [7:0] OFS_STACK_TOP_LOW     = 8'h08;
  localparam logic [7:0] OFS_RETURN_STACK_PTR  = 8'h0C;
  localparam logic [7:0] OFS_PC_LATCH_UPPER    = 8'h10;
  localparam logic [7:0] OFS_PC_LATCH_HIGH     = 8'h14;
  localparam logic [7:0] OFS_PC_LOW_BYTE       = 8'h18;
  localparam logic [7:0] OFS_TABLE_PTR_UPPER   = 8'h1C;
  localparam logic [7:0] OFS_TABLE_PTR_HIGH    = 8'h20;
  localparam logic [7:0] OFS_TABLE_PTR_LOW     = 8'h24;
  localparam logic [7:0] OFS_TABLE_DATA_LATCH  = 8'h28;
  localparam logic [7:0] OFS_MULT_RESULT_HIGH  = 8'h2C;
  localparam logic [7:0] OFS_MULT_RESULT_LOW   = 8'h30;
  localparam logic [7:0] OFS_IRQ_CTRL_PRIMARY  = 8'h34;
  localparam logic [7:0] OFS_IRQ_CTRL_SECOND   = 8'h38;
  localparam logic [7:0] OFS_IRQ_CTRL_THIRD    = 8'h3C;
  localparam logic [7:0] OFS_INDIRECT_PTR0_HI  = 8'h40;
  localparam logic [7:0] OFS_INDIRECT_PTR0_LO  = 8'h44;
  localparam logic [7:0] OFS_WORKING_ACC       = 8'h48;
  localparam logic [7:0] OFS_PORT_A_DATA       = 8'h4C;
  localparam logic [7:0] OFS_PORT_A_LATCH      = 8'h50;
  localparam logic [7:0] OFS_PORT_A_DIRECTION  = 8'h54;
  localparam logic [7:0] OFS_EVENT_STATUS      = 8'h58;
  localparam logic [7:0] OFS_EVENT_MASK        = 8'h5C;
  // Indirect virtual locations, pointers 0 and 1, five each
  localparam logic [7:0] OFS_INDIRECT_FIRST    = 8'h60;
  localparam logic [7:0] OFS_INDIRECT_LAST     = 8'h84;

  // ==========================================================================
  // Reset values
  localparam logic [4:0] RST_STACK_TOP_UPPER = 5'h00;
  localparam logic [7:0] RST_BYTE_ZERO       = 8'h00;
  localparam logic [5:0] RST_TABLE_PTR_UPPER = 6'h00;
  localparam logic [6:0] RST_IRQ_PRIMARY_HI  = 7'h00;
  localparam logic [7:0] RST_IRQ_SECOND      = 8'hFF;
  localparam logic [7:0] RST_IRQ_THIRD       = 8'hC0;
  localparam logic [4:0] RST_STACK_PTR       = 5'h00;
  localparam logic [7:0] RST_PORT_A_DIR      = 8'hFF;

  // ==========================================================================
  // Field positions and masks
  localparam int         STK_FULL_BIT    = 7;
  localparam int         STK_UNDER_BIT   = 6;
  localparam logic [4:0] STK_PTR_MAX     = 5'h1F;
  localparam int         GIE_HIGH_BIT    = 7;
  localparam int         GIE_LOW_BIT     = 6;
  localparam logic [7:0] PORT_A_OSC_BITS = 8'hC0;

  // Event status bits
  localparam int EV_POWER_ON = 0;
  localparam int EV_RESET    = 1;
  localparam int EV_WAKE_WDT = 2;
  localparam int EV_WAKE_IRQ = 3;
  localparam int EV_W        = 4;

  // ==========================================================================
  // Program counter figures
  localparam logic [PC_W-1:0] PC_STEP     = 21'h00_0002;
  localparam logic [PC_W-1:0] VECTOR_HIGH = 21'h00_0008;
  localparam logic [PC_W-1:0] VECTOR_LOW  = 21'h00_0018;

endpackage

// ### testbench/crr_core_register_reset_init_props.sv
// Port-level checker for the core register reset block
module crr_core_register_reset_init_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              por_event,
  input wire logic              reset_event,
  input wire logic              wake_wdt,
  input wire logic              wake_irq,
  input wire logic              wake_irq_high,
  input wire logic [20:0]       current_pc,
  input wire logic              osc_frees_pins,
  input wire logic [7:0]        port_a_out,
  input wire logic [7:0]        port_a_out_en_n,
  input wire logic [20:0]       resume_pc,
  input wire logic              resume_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  virt_zero_a: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h60
    |-> avs_readdata == 32'h0) else $error("virtual location returned data");
  reset_class_a: assert property ((por_event || reset_event) |=> resume_valid && resume_pc == 0)
    else $error("reset class did not restart at zero");
  pc_step_a: assert property (wake_wdt && !por_event && !reset_event && !wake_irq
    |=> resume_pc == $past(current_pc) + 21'h2) else $error("wake did not resume at pc plus two");
  vector_a: assert property (wake_irq && !por_event && !reset_event
    |=> resume_pc == ($past(wake_irq_high) ? 21'h8 : 21'h18)
    || resume_pc == $past(current_pc) + 21'h2) else $error("wrong irq wake address");
  valid_a: assert property (!(por_event || reset_event || wake_wdt || wake_irq) |=> !resume_valid)
    else $error("resume_valid without event");
  port_off_a: assert property (!osc_frees_pins [*2] |-> port_a_out[7:6] == 2'b00
    && port_a_out_en_n[7:6] == 2'b11) else $error("port bits 7:6 active");
endmodule // crr_core_register_reset_init_props

bind crr_core_register_reset_init
  crr_core_register_reset_init_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ### testbench/tb.sv
// Self-checking bench for the core register reset block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, rse = 0, wwdt = 0, wirq = 0, wih = 0, osc = 1;
  logic [7:0]  adr = 0, fl = 0, pins = 0, v, po, poe;
  logic [31:0] wd = 0, rdat;
  logic [20:0] pc = 0, rpc, pn;
  logic        wt, rv, irq, por = 0;
  logic [7:0]  expq[$];
  logic [20:0] rq[$];
  int          mismatches = 0, num_checks = 0, seed = 32'h47ba, i;
  // Direction register left out: its value after a non-power-on reset is open
  logic [15:0] rtab[14] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h1400,
    16'h1800, 16'h1C00, 16'h2000, 16'h2400, 16'h2800, 16'h38FF, 16'h3CC0, 16'h8800};
  crr_core_register_reset_init dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wt), .por_event(por), .reset_event(rse), .wake_wdt(wwdt), .wake_irq(wirq),
    .wake_irq_high(wih), .wake_flag_set(fl), .current_pc(pc), .osc_frees_pins(osc),
    .master_clear_input_n(1'b1), .port_a_pins(pins), .port_a_out(po), .port_a_out_en_n(poe),
    .resume_pc(rpc), .resume_valid(rv), .irq(irq));
  initial forever #5 clk = ~clk;
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    int n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      end_sim();
    end
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rdx(logic [7:0] a, logic [7:0] e);
    expq.push_back(e);
    bus(0, a, 8'h00);
  endtask
  task automatic irq_is(logic e);
    repeat (2) @(negedge clk);
    cmp("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk);
  endtask
  // One-cycle event pulse; e is the restart address the event must report
  task automatic pulse(int k, logic [20:0] e);
    rq.push_back(e);
    case (k)
      0: rse <= 1;
      1: wwdt <= 1;
      2: wirq <= 1;
      default: por <= 1;
    endcase
    @(posedge clk);
    {por, wirq, wwdt, rse} <= 4'h0;
    @(posedge clk);
  endtask
  always @(posedge clk) if (rd && wt === 1'b0) cmp("readdata", {24'h0, expq.pop_front()}, rdat);
  always @(posedge clk) if (rv === 1'b1) cmp("resume_pc", rq.pop_front(), rpc);
  initial begin
    pins <= $random(seed);
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (rtab[i]) rdx(rtab[i][15:8], rtab[i][7:0]);
    rdx(8'h54, 8'hFF);
    rdx(8'h60, 8'h00);
    for (i = 0; i < 'h40; i += 4) bus(1, i[7:0], $random(seed));
    bus(1, 8'h0C, 8'hE5);
    rdx(8'h0C, 8'hC5);
    pulse(3, 21'h0);
    rdx(8'h0C, 8'hC0);
    v = $random(seed);
    bus(1, 8'h2C, v);
    pulse(0, 21'h0);
    rdx(8'h2C, v);
    foreach (rtab[i]) rdx(rtab[i][15:8], rtab[i][7:0]);
    v = $random(seed);
    bus(1, 8'h14, v);
    pn = $random(seed);
    pc <= pn;
    pulse(1, pn + 21'h2);
    rdx(8'h18, pn[7:0] + 8'h2);
    rdx(8'h14, v);
    for (i = 0; i < 2; i++) begin
      bus(1, 8'h34, 8'h80 >> i);
      fl <= 8'h04;
      wih <= (i == 0);
      pc <= $random(seed);
      pulse(2, i ? 21'h18 : 21'h08);
      rdx(8'h00, {3'h0, pc[20:16]});
      rdx(8'h04, pc[15:8]);
      rdx(8'h08, pc[7:0]);
      rdx(8'h0C, i[7:0] + 8'h1);
      rdx(8'h18, i ? 8'h18 : 8'h08);
      rdx(8'h34, (8'h80 >> i) | 8'h04);
    end
    irq_is(0);
    bus(1, 8'h5C, 8'h08);
    irq_is(1);
    bus(1, 8'h58, 8'h08);
    irq_is(0);
    osc <= 0;
    bus(1, 8'h54, 8'h00);
    bus(1, 8'h50, 8'hFF);
    rdx(8'h50, 8'h3F);
    rdx(8'h4C, pins & 8'h3F);
    @(negedge clk);
    cmp("port_a_out", 8'h3F, po);
    cmp("port_a_out_en_n", 8'hC0, poe);
    end_sim();
  end
endmodule // tb
